// *** hw/rdcfg_pkg.sv ***
// Shared constants, types and lookups for the redriver control block
package rdcfg_pkg;

  // Clock rate and timing
  localparam int CLK_MHZ = 10;
  localparam int SLEEP_ENTRY_US = 2;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ;
  localparam int WAKE_EXIT_US = 100;
  localparam int WAKE_EXIT_CYC = WAKE_EXIT_US * CLK_MHZ;
  localparam int DET_SETTLE_US = 1;
  localparam int DET_SETTLE_CYC = DET_SETTLE_US * CLK_MHZ;
  localparam int RETRY_MS = 12;
  localparam int RETRY_CYC_DEF = RETRY_MS * 1000 * CLK_MHZ;
  localparam int RETRY_CNT_W = 20;
  localparam int SETTLE_CNT_W = 8;

  // Register map (byte addresses)
  localparam logic [11:0] REG_CTRL = 12'h0000;
  localparam logic [11:0] REG_STATUS = 12'h0004;
  localparam logic [11:0] REG_CONFIG = 12'h0008;
  localparam int CTRL_FORCE_SLEEP_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Three-level pin as seen by two input comparators
  typedef struct packed {
    logic above_hi;
    logic below_lo;
  } rdcfg_tri_pin_t;

  // Resolved three-level code
  typedef enum logic [1:0] {
    LVL_OPEN = 2'h0,
    LVL_LOW = 2'h1,
    LVL_HIGH = 2'h2
  } rdcfg_lvl_t;

  // De-emphasis steps
  typedef enum logic [2:0] {
    EMPH_0P0 = 3'h0,
    EMPH_2P2 = 3'h1,
    EMPH_3P5 = 3'h2,
    EMPH_4P4 = 3'h3,
    EMPH_5P2 = 3'h4,
    EMPH_6P0 = 3'h5
  } rdcfg_emph_t;

  // Per-channel analog settings; swing OPEN/LOW/HIGH = 1042/908/1127 mVpp,
  // boost OPEN/LOW/HIGH = 0/7/15 dB
  typedef struct packed {
    rdcfg_lvl_t swing;
    rdcfg_lvl_t boost;
    rdcfg_emph_t emph;
  } rdcfg_chan_cfg_t;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_PROBE = 3'h1,
    ST_SENSE = 3'h2,
    ST_RETRY = 3'h3,
    ST_ACTIVE = 3'h4
  } rdcfg_state_t;

  // De-emphasis from emphasis select and swing select
  function automatic rdcfg_emph_t rdcfg_emph_lookup(rdcfg_lvl_t de, rdcfg_lvl_t os);
    rdcfg_emph_t r;
    r = EMPH_0P0;
    if (de == LVL_LOW) begin
      r = (os == LVL_LOW) ? EMPH_2P2 : ((os == LVL_HIGH) ? EMPH_4P4 : EMPH_3P5);
    end else if (de == LVL_HIGH) begin
      r = (os == LVL_LOW) ? EMPH_5P2 : EMPH_6P0;
    end
    return r;
  endfunction : rdcfg_emph_lookup

endpackage : rdcfg_pkg

// *** hw/rdcfg_tri_level.sv ***
// Synchronises and resolves one three-level strap pin
module rdcfg_tri_level
  import rdcfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pin comparators
  input rdcfg_tri_pin_t pin,
  // Resolved code
  output rdcfg_lvl_t code
);

  rdcfg_tri_pin_t meta_ff;
  rdcfg_tri_pin_t sync_ff;
  rdcfg_lvl_t code_ff;
  rdcfg_lvl_t nxt_code;

  always_comb begin
    nxt_code = LVL_OPEN;
    if (sync_ff.above_hi && !sync_ff.below_lo) begin
      nxt_code = LVL_HIGH;
    end else if (sync_ff.below_lo && !sync_ff.above_hi) begin
      nxt_code = LVL_LOW;
    end
  end

  // Resolved every cycle, no reset needed for a new setting to apply
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
      code_ff <= LVL_OPEN;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      code_ff <= nxt_code;
    end
  end

  assign code = code_ff;

endmodule : rdcfg_tri_level

// *** hw/rdcfg_retry_timer.sv ***
// Free-running interval timer for detection retries
module rdcfg_retry_timer
  import rdcfg_pkg::*;
#(
  parameter logic [RETRY_CNT_W-1:0] PERIOD = RETRY_CNT_W'(RETRY_CYC_DEF)
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Control
  input wire logic restart,
  // Interval elapsed
  output logic tick
);

  logic [RETRY_CNT_W-1:0] cnt_ff;
  logic [RETRY_CNT_W-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt = cnt_ff + 1'b1;
    if (restart) begin
      nxt_cnt = '0;
    end else if (cnt_ff == PERIOD - 1'b1) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : rdcfg_retry_timer

// *** hw/rdcfg_top.sv ***
// Redriver pin configuration, power-state machine and register slave
//
// Overview of operation
// - Swing select sets transition-bit output amplitude
// - Boost select sets receive equalization gain
// - De-emphasis from emphasis and swing selects
// - All six selects are three-level inputs
// - Each channel keeps its own settings
// - Mode input high runs, low sleeps
// - Falling mode enters sleep within 2 us
// - Sleep floats all terminations, stops link
// - Rising mode leaves sleep to detect, 100 us
// - Broken link or no far end: detect mode
// - Detect mode floats both input terminations
// - Reconnection returns to normal mode automatically
// - Detect cycle floats inputs, senses, then terminates
// - Missing far end: float transmitter, retry 12 ms
// - Input below threshold idles matching transmitter
module rdcfg_top
  import rdcfg_pkg::*;
#(
  parameter logic [RETRY_CNT_W-1:0] RETRY_CYC = RETRY_CNT_W'(RETRY_CYC_DEF)
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Strap pins
  input rdcfg_tri_pin_t swing_select_ch1,
  input rdcfg_tri_pin_t swing_select_ch2,
  input rdcfg_tri_pin_t rx_boost_select_ch1,
  input rdcfg_tri_pin_t rx_boost_select_ch2,
  input rdcfg_tri_pin_t tx_emphasis_select_ch1,
  input rdcfg_tri_pin_t tx_emphasis_select_ch2,
  input wire logic mode_run,
  // Analog sense (bit 0 channel 1, bit 1 channel 2)
  input wire logic [1:0] far_end_sense,
  input wire logic [1:0] signal_detect,
  // Analog control
  output rdcfg_chan_cfg_t cfg_ch1,
  output rdcfg_chan_cfg_t cfg_ch2,
  output logic [1:0] rx_term_en,
  output logic [1:0] tx_term_en,
  output logic [1:0] tx_idle,
  output logic rx_detect_probe,
  output logic core_power_en
);

  localparam int ENTRY_BOUND = SLEEP_ENTRY_CYC;
  localparam int WAKE_BOUND = WAKE_EXIT_CYC;

  rdcfg_lvl_t os1_code;
  rdcfg_lvl_t os2_code;
  rdcfg_lvl_t eq1_code;
  rdcfg_lvl_t eq2_code;
  rdcfg_lvl_t de1_code;
  rdcfg_lvl_t de2_code;

  rdcfg_tri_level u_os1 (.clk_sys(clk_sys), .rst_b(rst_b), .pin(swing_select_ch1),
    .code(os1_code));
  rdcfg_tri_level u_os2 (.clk_sys(clk_sys), .rst_b(rst_b), .pin(swing_select_ch2),
    .code(os2_code));
  rdcfg_tri_level u_eq1 (.clk_sys(clk_sys), .rst_b(rst_b), .pin(rx_boost_select_ch1),
    .code(eq1_code));
  rdcfg_tri_level u_eq2 (.clk_sys(clk_sys), .rst_b(rst_b), .pin(rx_boost_select_ch2),
    .code(eq2_code));
  rdcfg_tri_level u_de1 (.clk_sys(clk_sys), .rst_b(rst_b), .pin(tx_emphasis_select_ch1),
    .code(de1_code));
  rdcfg_tri_level u_de2 (.clk_sys(clk_sys), .rst_b(rst_b), .pin(tx_emphasis_select_ch2),
    .code(de2_code));

  // Channel settings
  rdcfg_chan_cfg_t cfg1_ff;
  rdcfg_chan_cfg_t cfg2_ff;
  rdcfg_chan_cfg_t nxt_cfg1;
  rdcfg_chan_cfg_t nxt_cfg2;

  always_comb begin
    nxt_cfg1.swing = os1_code;
    nxt_cfg1.boost = eq1_code;
    nxt_cfg1.emph = rdcfg_emph_lookup(de1_code, os1_code);
    nxt_cfg2.swing = os2_code;
    nxt_cfg2.boost = eq2_code;
    nxt_cfg2.emph = rdcfg_emph_lookup(de2_code, os2_code);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg1_ff <= '0;
      cfg2_ff <= '0;
    end else begin
      cfg1_ff <= nxt_cfg1;
      cfg2_ff <= nxt_cfg2;
    end
  end

  // Synchronisers for asynchronous pins
  logic mode_meta_ff;
  logic mode_sync_ff;
  logic [1:0] far_meta_ff;
  logic [1:0] far_sync_ff;
  logic [1:0] sig_meta_ff;
  logic [1:0] sig_sync_ff;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_meta_ff <= 1'b0;
      mode_sync_ff <= 1'b0;
      far_meta_ff <= 2'h0;
      far_sync_ff <= 2'h0;
      sig_meta_ff <= 2'h0;
      sig_sync_ff <= 2'h0;
    end else begin
      mode_meta_ff <= mode_run;
      mode_sync_ff <= mode_meta_ff;
      far_meta_ff <= far_end_sense;
      far_sync_ff <= far_meta_ff;
      sig_meta_ff <= signal_detect;
      sig_sync_ff <= sig_meta_ff;
    end
  end

  // Register slave
  logic ctrl_force_sleep_ff;
  logic nxt_force_sleep;
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [11:0] wr_addr_ff;
  logic [11:0] nxt_wr_addr;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic hreadyout_ff;
  logic addr_phase;
  rdcfg_state_t state_ff;
  logic [1:0] found_ff;
  logic [1:0] tx_term_ff;

  assign addr_phase = hsel && hready && htrans[1];

  always_comb begin
    nxt_wr_pend = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_hrdata = 32'h0000_0000;
    nxt_force_sleep = ctrl_force_sleep_ff;
    if (wr_pend_ff && wr_addr_ff == REG_CTRL) begin
      nxt_force_sleep = hwdata[CTRL_FORCE_SLEEP_BIT];
    end
    if (addr_phase && hwrite && hsize == HSIZE_WORD && haddr[31:12] == 20'h0_0000) begin
      nxt_wr_pend = 1'b1;
      nxt_wr_addr = haddr[11:0];
    end
    if (addr_phase && !hwrite && haddr[31:12] == 20'h0_0000) begin
      case (haddr[11:0])
        REG_CTRL: nxt_hrdata = {31'h0000_0000, ctrl_force_sleep_ff};
        REG_STATUS: nxt_hrdata = {23'h00_0000, tx_term_ff, sig_sync_ff, far_sync_ff,
          state_ff};
        REG_CONFIG: nxt_hrdata = {17'h0_0000, cfg2_ff, 1'b0, cfg1_ff};
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_force_sleep_ff <= CTRL_RESET;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
    end else begin
      ctrl_force_sleep_ff <= nxt_force_sleep;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
    end
  end

  // Power-state machine
  logic sleep_req;
  logic retry_tick;
  logic retry_restart;
  rdcfg_state_t nxt_state;
  logic [SETTLE_CNT_W-1:0] settle_ff;
  logic [SETTLE_CNT_W-1:0] nxt_settle;
  logic [1:0] nxt_found;
  logic [1:0] rx_term_ff;
  logic [1:0] nxt_rx_term;
  logic [1:0] nxt_tx_term;
  logic [1:0] tx_idle_ff;
  logic [1:0] nxt_tx_idle;
  logic probe_ff;
  logic nxt_probe;
  logic core_on_ff;
  logic nxt_core_on;

  assign sleep_req = !mode_sync_ff || ctrl_force_sleep_ff;
  assign retry_restart = (nxt_state == ST_RETRY) && (state_ff != ST_RETRY);

  rdcfg_retry_timer #(.PERIOD(RETRY_CYC)) u_retry (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .restart(retry_restart),
    .tick(retry_tick)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_settle = settle_ff;
    nxt_found = found_ff;
    case (state_ff)
      ST_SLEEP: begin
        if (!sleep_req) begin
          nxt_state = ST_PROBE;
        end
      end
      ST_PROBE: begin
        nxt_state = ST_SENSE;
        nxt_settle = SETTLE_CNT_W'(DET_SETTLE_CYC - 1);
      end
      ST_SENSE: begin
        if (settle_ff != '0) begin
          nxt_settle = settle_ff - 1'b1;
        end else begin
          nxt_found = far_sync_ff;
          nxt_state = (&far_sync_ff) ? ST_ACTIVE : ST_RETRY;
        end
      end
      ST_RETRY: begin
        if (retry_tick) begin
          nxt_state = ST_PROBE;
        end
      end
      ST_ACTIVE: begin
        if (!(&far_sync_ff)) begin
          nxt_state = ST_PROBE;
        end
      end
      default: nxt_state = ST_SLEEP;
    endcase
    if (sleep_req) begin
      nxt_state = ST_SLEEP;
    end
  end

  always_comb begin
    nxt_rx_term = 2'h0;
    nxt_tx_term = 2'h0;
    nxt_tx_idle = 2'h3;
    nxt_probe = 1'b0;
    nxt_core_on = 1'b0;
    case (nxt_state)
      ST_SLEEP: nxt_core_on = 1'b0;
      ST_PROBE, ST_SENSE: nxt_probe = 1'b1;
      ST_RETRY: nxt_tx_term = nxt_found;
      ST_ACTIVE: begin
        nxt_rx_term = 2'h3;
        nxt_tx_term = 2'h3;
        nxt_tx_idle = ~sig_sync_ff;
        nxt_core_on = 1'b1;
      end
      default: nxt_core_on = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_SLEEP;
      settle_ff <= '0;
      found_ff <= 2'h0;
      rx_term_ff <= 2'h0;
      tx_term_ff <= 2'h0;
      tx_idle_ff <= 2'h3;
      probe_ff <= 1'b0;
      core_on_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      settle_ff <= nxt_settle;
      found_ff <= nxt_found;
      rx_term_ff <= nxt_rx_term;
      tx_term_ff <= nxt_tx_term;
      tx_idle_ff <= nxt_tx_idle;
      probe_ff <= nxt_probe;
      core_on_ff <= nxt_core_on;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign cfg_ch1 = cfg1_ff;
  assign cfg_ch2 = cfg2_ff;
  assign rx_term_en = rx_term_ff;
  assign tx_term_en = tx_term_ff;
  assign tx_idle = tx_idle_ff;
  assign rx_detect_probe = probe_ff;
  assign core_power_en = core_on_ff;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_emph_decode: assert property (
    ##1 cfg1_ff.emph == rdcfg_emph_lookup($past(de1_code), $past(os1_code)))
    else $error("channel 1 emphasis decode wrong");

  a_chan_split: assert property (
    ##1 cfg2_ff.swing == $past(os2_code) && cfg1_ff.swing == $past(os1_code))
    else $error("channel swing settings not independent");

  a_sleep_entry: assert property (
    $rose(sleep_req) |-> ##[1:ENTRY_BOUND] state_ff == ST_SLEEP)
    else $error("sleep not entered in time");

  a_sleep_float: assert property (
    state_ff == ST_SLEEP |-> rx_term_en == 2'h0 && tx_term_en == 2'h0 && !core_power_en)
    else $error("terminations driven while asleep");

  a_wake_detect: assert property (
    state_ff == ST_SLEEP && !sleep_req |-> ##[1:WAKE_BOUND] state_ff == ST_PROBE)
    else $error("no detect after wake");

  a_break_detect: assert property (
    state_ff == ST_ACTIVE && !(&far_sync_ff) |=> state_ff != ST_ACTIVE)
    else $error("broken link kept active");

  a_detect_rxoff: assert property (
    state_ff inside {ST_PROBE, ST_SENSE, ST_RETRY} |-> rx_term_en == 2'h0)
    else $error("input termination on during detect");

  a_both_found: assert property (
    state_ff == ST_SENSE && settle_ff == '0 && (&far_sync_ff) && !sleep_req
    |=> state_ff == ST_ACTIVE && rx_term_en == 2'h3 && tx_term_en == 2'h3)
    else $error("terminations not applied after detect");

  a_retry_float: assert property (
    state_ff == ST_RETRY |-> tx_term_en == found_ff && found_ff != 2'h3)
    else $error("missing transmitter not floated");

  a_retry_tick: assert property (
    state_ff == ST_RETRY && retry_tick && !sleep_req |=> state_ff == ST_PROBE)
    else $error("retry did not restart detect");

  a_idle_follow: assert property (
    nxt_state == ST_ACTIVE && !sig_sync_ff[0] |=> tx_idle[0])
    else $error("transmitter not idled on lost signal");

  c_reach_active: cover property (state_ff == ST_SENSE ##1 state_ff == ST_ACTIVE);
  c_retry_loop: cover property (state_ff == ST_RETRY ##1 state_ff == ST_PROBE);
  c_sleep_wake: cover property (state_ff == ST_SLEEP ##1 state_ff == ST_PROBE);
  c_break_link: cover property (state_ff == ST_ACTIVE ##1 state_ff == ST_PROBE);

endmodule : rdcfg_top

// *** tb/rdcfg_far_end.sv ***
// Far-end model: receiver terminations and link traffic per channel
module rdcfg_far_end (
  // Clock
  input wire logic clk_sys,
  // Scenario control
  input wire logic [1:0] attach,
  input wire logic [1:0] send,
  // Sensed by the redriver
  output logic [1:0] far_end_sense,
  output logic [1:0] signal_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  // A detached channel shows neither termination nor traffic
  always_ff @(posedge clk_sys) begin
    far_end_sense <= attach;
    signal_detect <= attach & send;
  end
endmodule : rdcfg_far_end

// *** tb/rdcfg_top_bench.sv ***
// Self-checking bench for the redriver control block
module rdcfg_top_bench
  import rdcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] RETRY_SIM = 20'h0_0032;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic mode_run = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [1:0] attach = 2'h3;
  logic [1:0] send = 2'h3;
  logic hreadyout;
  logic hresp;
  rdcfg_tri_pin_t sw1 = '0, sw2 = '0, bo1 = '0, bo2 = '0, de1 = '0, de2 = '0;
  logic [1:0] far_end_sense, signal_detect, rx_term_en, tx_term_en, tx_idle;
  rdcfg_chan_cfg_t cfg_ch1, cfg_ch2;
  logic rx_detect_probe, core_power_en;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int k;

  rdcfg_top #(.RETRY_CYC(RETRY_SIM)) i_rdcfg_top (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .swing_select_ch1(sw1), .swing_select_ch2(sw2), .rx_boost_select_ch1(bo1),
    .rx_boost_select_ch2(bo2), .tx_emphasis_select_ch1(de1),
    .tx_emphasis_select_ch2(de2), .mode_run(mode_run), .far_end_sense(far_end_sense),
    .signal_detect(signal_detect), .cfg_ch1(cfg_ch1), .cfg_ch2(cfg_ch2),
    .rx_term_en(rx_term_en), .tx_term_en(tx_term_en), .tx_idle(tx_idle),
    .rx_detect_probe(rx_detect_probe), .core_power_en(core_power_en)
  );

  rdcfg_far_end i_rdcfg_far_end (
    .clk_sys(clk_sys), .attach(attach), .send(send),
    .far_end_sense(far_end_sense), .signal_detect(signal_detect)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic rdcfg_tri_pin_t pin(int v);
    return rdcfg_tri_pin_t'(v[1:0]);
  endfunction : pin

  // Only one comparator firing selects a driven level
  function automatic rdcfg_lvl_t lvl(rdcfg_tri_pin_t p);
    return (p == 2'h2) ? LVL_HIGH : ((p == 2'h1) ? LVL_LOW : LVL_OPEN);
  endfunction : lvl

  function automatic rdcfg_chan_cfg_t exp_cfg(rdcfg_tri_pin_t s, rdcfg_tri_pin_t b,
                                              rdcfg_tri_pin_t d);
    rdcfg_emph_t e;
    e = EMPH_0P0;
    if (lvl(d) == LVL_LOW) begin
      e = (lvl(s) == LVL_OPEN) ? EMPH_3P5 : ((lvl(s) == LVL_LOW) ? EMPH_2P2 : EMPH_4P4);
    end
    if (lvl(d) == LVL_HIGH) begin
      e = (lvl(s) == LVL_LOW) ? EMPH_5P2 : EMPH_6P0;
    end
    return '{lvl(s), lvl(b), e};
  endfunction : exp_cfg

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns: value %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(32'(hresp), 32'h0000_0000);
  endtask : ahb_xfer

  // Waits for core power (sel 0) or the detect probe (sel 1), bounded
  task automatic wait_for(input int sel, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? core_power_en : rx_detect_probe) !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    check(32'(n < lim), 32'h0000_0001);
  endtask : wait_for

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(89));
    repeat (8) @(posedge clk_sys);
    check(32'({hreadyout, tx_idle, core_power_en}), 32'h0000_000e);
    check(32'(cfg_ch1), 32'h0000_0000);
    rst_b <= 1'b1;
    wait_for(1, 20);
    check(32'(rx_term_en), 32'h0000_0000);
    wait_for(0, 40);
    check(32'({rx_term_en, tx_term_en}), 32'h0000_000f);
    check(32'(tx_idle), 32'h0000_0000);
    send <= 2'h1;
    repeat (6) @(posedge clk_sys);
    check(32'(tx_idle), 32'h0000_0002);
    send <= 2'h3;
    // Strap decode: all swing/emphasis pairs first, then random pins
    for (int i = 0; i < 24; i++) begin
      k = (i < 16) ? i : int'($urandom);
      sw1 <= pin(k);
      de1 <= pin(k >> 2);
      bo1 <= pin(i + k);
      sw2 <= pin(k >> 2);
      de2 <= pin(k);
      bo2 <= pin(3 - k);
      repeat (6) @(posedge clk_sys);
      check(32'(cfg_ch1), 32'(exp_cfg(sw1, bo1, de1)));
      check(32'(cfg_ch2), 32'(exp_cfg(sw2, bo2, de2)));
    end
    ahb_xfer(32'(REG_CONFIG), 1'b0, 32'h0000_0000);
    check(rd, 32'({exp_cfg(sw2, bo2, de2), 1'b0, exp_cfg(sw1, bo1, de1)}));
    // Channel 2 far end unplugged
    attach <= 2'h1;
    wait_for(1, 20);
    check(32'(rx_term_en), 32'h0000_0000);
    repeat (20) @(posedge clk_sys);
    ahb_xfer(32'(REG_STATUS), 1'b0, 32'h0000_0000);
    check(32'(rd[2:0]), 32'(ST_RETRY));
    check(32'({core_power_en, tx_term_en}), 32'h0000_0001);
    wait_for(1, 60);
    attach <= 2'h3;
    wait_for(0, 100);
    // Sleep by the mode input, then wake
    mode_run <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check(32'({core_power_en, rx_term_en, tx_term_en}), 32'h0000_0000);
    mode_run <= 1'b1;
    wait_for(1, 1000);
    wait_for(0, 100);
    // Sleep forced over the bus, unmapped access, release
    ahb_xfer(32'(REG_CTRL), 1'b1, 32'h0000_0001);
    repeat (20) @(posedge clk_sys);
    check(32'({core_power_en, tx_term_en}), 32'h0000_0000);
    ahb_xfer(32'(REG_CTRL), 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    ahb_xfer(32'h0000_0010, 1'b1, 32'h0000_ffff);
    ahb_xfer(32'h0000_0010, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    ahb_xfer(32'(REG_CTRL), 1'b1, 32'h0000_0000);
    // A write above the register window must not alias onto the control word
    ahb_xfer(32'h0000_1000, 1'b1, 32'h0000_0001);
    wait_for(0, 1000);
    give_verdict();
  end
endmodule : rdcfg_top_bench
